//--- shared/tcfg_pkg.sv
// Package of constants and types for the thermal configuration block
package tcfg_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CFG_OFFSET = 8'h01;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_RO_MASK = 16'hF800;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int HYST_HI_POS = 10;
  localparam int HYST_LO_POS = 9;
  localparam int SHUTDOWN_POS = 8;
  localparam int CRIT_LOCK_POS = 7;
  localparam int WIN_LOCK_POS = 6;
  localparam int CLEAR_ALERT_POS = 5;
  localparam int ALERT_STATUS_POS = 4;
  localparam int ALERT_OE_POS = 3;
  localparam int CRIT_ONLY_POS = 2;
  localparam int ALERT_POL_POS = 1;
  localparam int ALERT_MODE_POS = 0;
  // ****************************************
  // Temperature format, 0.125 degree steps, 13 bit signed
  // ****************************************
  localparam int TEMP_W = 13;
  localparam logic [12:0] HYST_OFF = 13'h0000;
  localparam logic [12:0] HYST_1P5 = 13'h000C;
  localparam logic [12:0] HYST_3P0 = 13'h0018;
  localparam logic [12:0] HYST_6P0 = 13'h0030;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 10000000;
  localparam int AUTO_OFF_MS = 30;
  localparam int AUTO_OFF_CYCLES = CLK_HZ / 1000 * AUTO_OFF_MS;
  // ****************************************
  // Power-up states
  // ****************************************
  typedef enum logic [1:0] {
    TCFG_PWR_COUNT = 2'b00,
    TCFG_PWR_CHECK = 2'b01,
    TCFG_PWR_DONE = 2'b10
  } tcfg_pwr_type;
endpackage

//--- rtl/tcfg_window.sv
// Window flag evaluation with hysteresis
`timescale 1ns/1ps
module tcfg_window
  import tcfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample,
  input wire logic signed [12:0] temp,
  input wire logic signed [12:0] upper,
  input wire logic signed [12:0] lower,
  input wire logic [1:0] hyst_sel,
  output logic above,
  output logic below
);
  logic above_r;
  logic above_nxt;
  logic below_r;
  logic below_nxt;
  logic signed [12:0] hyst;
  logic signed [13:0] up_rel;
  logic signed [13:0] lo_rel;

  always_comb
  begin
    case (hyst_sel) // [RL2]
      2'b00: hyst = HYST_OFF;
      2'b01: hyst = HYST_1P5;
      2'b10: hyst = HYST_3P0;
      default: hyst = HYST_6P0;
    endcase
    // Extra bit so boundary minus hysteresis cannot wrap
    up_rel = 14'(upper) - 14'(hyst);
    lo_rel = 14'(lower) - 14'(hyst);
    above_nxt = above_r;
    below_nxt = below_r;
    if (sample) // [RL19]
    begin
      if (temp > upper)
        above_nxt = 1'b1; // [RL3]
      else if (14'(temp) <= up_rel)
        above_nxt = 1'b0; // [RL4]
      if (temp >= lower)
        below_nxt = 1'b0; // [RL5]
      else if (14'(temp) <= lo_rel)
        below_nxt = 1'b1; // [RL6]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      above_r <= 1'b0;
      below_r <= 1'b0;
    end
    else
    begin
      above_r <= above_nxt;
      below_r <= below_nxt;
    end
  end

  assign above = above_r;
  assign below = below_r;
endmodule // tcfg_window

//--- rtl/tcfg_autooff.sv
// Power-up automatic turn-off timer
`timescale 1ns/1ps
module tcfg_autooff
  import tcfg_pkg::*;
#(
  parameter int OFF_CYCLES = AUTO_OFF_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic supply_ok,
  output logic turn_off
);
  tcfg_pwr_type state_r;
  tcfg_pwr_type state_nxt;
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic off_r;
  logic off_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    off_nxt = 1'b0;
    case (state_r)
      TCFG_PWR_COUNT:
      begin
        // Strap judged only at the check; its synchroniser still
        // shows the reset level in the first cycles after reset
        if (cnt_r == 20'(OFF_CYCLES - 1))
          state_nxt = TCFG_PWR_CHECK; // [RL14]
        else
          cnt_nxt = cnt_r + 20'h0_0001;
      end
      TCFG_PWR_CHECK:
      begin
        off_nxt = enable && !supply_ok; // [RL14]
        state_nxt = TCFG_PWR_DONE;
      end
      TCFG_PWR_DONE: state_nxt = TCFG_PWR_DONE;
      default: state_nxt = TCFG_PWR_DONE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= TCFG_PWR_COUNT;
      cnt_r <= 20'h0_0000;
      off_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      off_r <= off_nxt;
    end
  end

  assign turn_off = off_r;
endmodule // tcfg_autooff

//--- rtl/tcfg_top.sv
// Configuration register, hysteresis and shutdown control of the sensor
// ****************************************
// Contract
// RL1: Bits 15:11 are read-only zero; host writes zeros there.
// RL2: Hysteresis select 00 off, 01 1.5, 10 3, 11 6 degrees.
// RL3: Above flag sets when temperature exceeds upper boundary.
// RL4: Above flag holds until temperature at or below upper minus hysteresis.
// RL5: Below flag clears when temperature at or above lower boundary.
// RL6: Below flag sets only at or below lower minus hysteresis.
// RL7: Event output uses the same hysteresis as the window flags; the critical compare feeding it has none.
// RL8: Hysteresis writes ignored while either lock bit is set.
// RL9: Shutdown stops sensing, conversions and events.
// RL10: Locked: shutdown cannot be set, but can always be cleared.
// RL11: Bus time-out disabled while shut down.
// RL12: Non-volatile reads served regardless of shutdown.
// RL13: Non-volatile writes blocked while shut down.
// RL14: Auto turn-off checks supply 30 ms after start, sets shutdown.
// RL15: Writing zero to shutdown restarts sensor and conversions.
// RL16: Auto turn-off enable is factory-only, not bus readable.
// RL17: All configuration bits reset to zero.
// RL18: Lock bits stay set until power-on reset.
// RL19: Window flags re-evaluated on each latched conversion result.
// ****************************************
`timescale 1ns/1ps
module tcfg_top
  import tcfg_pkg::*;
#(
  parameter int OFF_CYCLES = AUTO_OFF_CYCLES
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic CONV_DONE,
  input wire logic [12:0] CONV_TEMP,
  input wire logic [12:0] UPPER_LIMIT,
  input wire logic [12:0] LOWER_LIMIT,
  input wire logic [12:0] CRIT_LIMIT,
  input wire logic FACTORY_AUTO_OFF,
  input wire logic SUPPLY_OK,
  input wire logic NV_WR_REQ,
  input wire logic NV_RD_REQ,
  output logic NV_WR_GO,
  output logic NV_RD_GO,
  output logic TIMEOUT_EN,
  output logic SENSOR_EN,
  output logic CONV_EN,
  output logic ABOVE_WINDOW,
  output logic BELOW_WINDOW,
  output logic ABOVE_CRIT,
  output logic ALERT_OUT,
  output logic ALERT_OE_N
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] fac_sync_r;
  logic [1:0] sup_sync_r;
  logic [1:0] fac_sync_nxt;
  logic [1:0] sup_sync_nxt;

  always_comb
  begin
    fac_sync_nxt = {fac_sync_r[0], FACTORY_AUTO_OFF};
    sup_sync_nxt = {sup_sync_r[0], SUPPLY_OK};
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      fac_sync_r <= 2'b00;
      sup_sync_r <= 2'b00;
    end
    else
    begin
      fac_sync_r <= fac_sync_nxt;
      sup_sync_r <= sup_sync_nxt;
    end
  end

  // ****************************************
  // Configuration register
  // ****************************************
  logic [1:0] hyst_sel_r;
  logic [1:0] hyst_sel_nxt;
  logic shutdown_r;
  logic shutdown_nxt;
  logic crit_lock_r;
  logic crit_lock_nxt;
  logic win_lock_r;
  logic win_lock_nxt;
  logic alert_oe_r;
  logic alert_oe_nxt;
  logic crit_only_r;
  logic crit_only_nxt;
  logic alert_pol_r;
  logic alert_pol_nxt;
  logic alert_mode_r;
  logic alert_mode_nxt;
  logic alert_status_r;
  logic alert_status_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic locked;
  logic cfg_wr;
  logic auto_off;
  logic above_w;
  logic below_w;
  logic crit_r;
  logic crit_nxt;
  logic conv_ok;
  logic [15:0] wdata;

  assign locked = crit_lock_r | win_lock_r;
  assign cfg_wr = REG_WR && (REG_ADDR == CFG_OFFSET);
  // Reserved bits dropped here so nothing stray can be stored
  assign wdata = REG_WDATA & ~CFG_RO_MASK; // [RL1]
  // Results taken only while the sensor runs
  assign conv_ok = CONV_DONE && !shutdown_r; // [RL9]

  // Factory enable comes only from the strap, never from the bus
  tcfg_autooff #(
    .OFF_CYCLES(OFF_CYCLES)
  ) u_autooff (
    .clk(CLK),
    .reset_n(RESET_N),
    .enable(fac_sync_r[1]), // [RL16]
    .supply_ok(sup_sync_r[1]),
    .turn_off(auto_off)
  );

  tcfg_window u_window (
    .clk(CLK),
    .reset_n(RESET_N),
    .sample(conv_ok), // [RL19]
    .temp(CONV_TEMP),
    .upper(UPPER_LIMIT),
    .lower(LOWER_LIMIT),
    .hyst_sel(hyst_sel_r),
    .above(above_w),
    .below(below_w)
  );

  always_comb
  begin
    hyst_sel_nxt = hyst_sel_r;
    shutdown_nxt = shutdown_r;
    crit_lock_nxt = crit_lock_r;
    win_lock_nxt = win_lock_r;
    alert_oe_nxt = alert_oe_r;
    crit_only_nxt = crit_only_r;
    alert_pol_nxt = alert_pol_r;
    alert_mode_nxt = alert_mode_r;
    if (cfg_wr)
    begin
      if (!locked)
      begin
        hyst_sel_nxt = wdata[HYST_HI_POS:HYST_LO_POS]; // [RL8]
        alert_oe_nxt = wdata[ALERT_OE_POS];
        crit_only_nxt = wdata[CRIT_ONLY_POS];
        alert_pol_nxt = wdata[ALERT_POL_POS];
      end
      // Set refused when locked, clear always honoured
      if (!wdata[SHUTDOWN_POS])
        shutdown_nxt = 1'b0; // [RL10] [RL15]
      else if (!locked)
        shutdown_nxt = 1'b1; // [RL10]
      alert_mode_nxt = wdata[ALERT_MODE_POS];
      // Locks are sticky; only reset can clear them
      crit_lock_nxt = crit_lock_r | wdata[CRIT_LOCK_POS]; // [RL18]
      win_lock_nxt = win_lock_r | wdata[WIN_LOCK_POS]; // [RL18]
    end
    // Auto turn-off wins over a same-cycle write
    if (auto_off)
      shutdown_nxt = 1'b1; // [RL14]
  end

  // ****************************************
  // Event logic and read data
  // ****************************************
  logic alert_cond;

  always_comb
  begin
    crit_nxt = crit_r;
    if (conv_ok)
      crit_nxt = $signed(CONV_TEMP) > $signed(CRIT_LIMIT);
    // Window flags already carry hysteresis
    alert_cond = crit_only_r ? crit_r : (crit_r | above_w | below_w); // [RL7]
    alert_status_nxt = alert_status_r;
    if (shutdown_r)
      alert_status_nxt = 1'b0; // [RL9]
    else if (!alert_mode_r)
      alert_status_nxt = alert_cond;
    else if (alert_cond && !alert_status_r)
      alert_status_nxt = 1'b1;
    else if (cfg_wr && wdata[CLEAR_ALERT_POS])
      alert_status_nxt = 1'b0;
    rdata_nxt = 16'h0000;
    if (REG_RD && REG_ADDR == CFG_OFFSET)
    begin
      rdata_nxt[HYST_HI_POS:HYST_LO_POS] = hyst_sel_r;
      rdata_nxt[SHUTDOWN_POS] = shutdown_r;
      rdata_nxt[CRIT_LOCK_POS] = crit_lock_r;
      rdata_nxt[WIN_LOCK_POS] = win_lock_r;
      rdata_nxt[ALERT_STATUS_POS] = alert_status_r;
      rdata_nxt[ALERT_OE_POS] = alert_oe_r;
      rdata_nxt[CRIT_ONLY_POS] = crit_only_r;
      rdata_nxt[ALERT_POL_POS] = alert_pol_r;
      rdata_nxt[ALERT_MODE_POS] = alert_mode_r;
    end
  end

  // ****************************************
  // Registers and outputs
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      hyst_sel_r <= CFG_RESET[HYST_HI_POS:HYST_LO_POS]; // [RL17]
      shutdown_r <= CFG_RESET[SHUTDOWN_POS];
      crit_lock_r <= CFG_RESET[CRIT_LOCK_POS];
      win_lock_r <= CFG_RESET[WIN_LOCK_POS];
      alert_oe_r <= CFG_RESET[ALERT_OE_POS];
      crit_only_r <= CFG_RESET[CRIT_ONLY_POS];
      alert_pol_r <= CFG_RESET[ALERT_POL_POS];
      alert_mode_r <= CFG_RESET[ALERT_MODE_POS];
      alert_status_r <= CFG_RESET[ALERT_STATUS_POS];
      crit_r <= 1'b0;
      rdata_r <= 16'h0000;
      NV_WR_GO <= 1'b0;
      NV_RD_GO <= 1'b0;
      TIMEOUT_EN <= 1'b0;
      SENSOR_EN <= 1'b0;
      CONV_EN <= 1'b0;
      ABOVE_WINDOW <= 1'b0;
      BELOW_WINDOW <= 1'b0;
      ABOVE_CRIT <= 1'b0;
      ALERT_OUT <= 1'b0;
      ALERT_OE_N <= 1'b1;
    end
    else
    begin
      hyst_sel_r <= hyst_sel_nxt;
      shutdown_r <= shutdown_nxt;
      crit_lock_r <= crit_lock_nxt;
      win_lock_r <= win_lock_nxt;
      alert_oe_r <= alert_oe_nxt;
      crit_only_r <= crit_only_nxt;
      alert_pol_r <= alert_pol_nxt;
      alert_mode_r <= alert_mode_nxt;
      alert_status_r <= alert_status_nxt;
      crit_r <= crit_nxt;
      rdata_r <= rdata_nxt;
      NV_WR_GO <= NV_WR_REQ && !shutdown_nxt; // [RL13]
      NV_RD_GO <= NV_RD_REQ; // [RL12]
      TIMEOUT_EN <= !shutdown_nxt; // [RL11]
      SENSOR_EN <= !shutdown_nxt; // [RL9]
      CONV_EN <= !shutdown_nxt; // [RL9] [RL15]
      ABOVE_WINDOW <= above_w;
      BELOW_WINDOW <= below_w;
      ABOVE_CRIT <= crit_r;
      // Open-drain: pin level is pull-up unless enabled and the level to show is low
      ALERT_OUT <= 1'b0;
      ALERT_OE_N <= !(alert_oe_r && (alert_status_nxt ^ alert_pol_r));
    end
  end

  assign REG_RDATA = rdata_r;
endmodule // tcfg_top

//--- bench/tcfg_top_sva.sv
// Concurrent checks on the thermal configuration block ports
`timescale 1ns/1ps
module tcfg_top_sva
  import tcfg_pkg::*;
#(
  parameter int OFF_CYCLES = AUTO_OFF_CYCLES
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic CONV_DONE,
  input wire logic [12:0] CONV_TEMP,
  input wire logic [12:0] UPPER_LIMIT,
  input wire logic [12:0] LOWER_LIMIT,
  input wire logic FACTORY_AUTO_OFF,
  input wire logic NV_RD_REQ,
  input wire logic NV_WR_GO,
  input wire logic NV_RD_GO,
  input wire logic TIMEOUT_EN,
  input wire logic SENSOR_EN,
  input wire logic CONV_EN,
  input wire logic ABOVE_WINDOW,
  input wire logic BELOW_WINDOW
);
  // ****
  // Properties
  // ****
  // Widest step; past it a flag is decided whatever the code
  localparam int HMAX = 48;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_conv;
    CONV_DONE && SENSOR_EN;
  endsequence
  // Strap excluded: auto turn-off may win the same edge
  sequence s_clear_wr;
    REG_WR && REG_ADDR == CFG_OFFSET && !REG_WDATA[8] && !FACTORY_AUTO_OFF;
  endsequence
  a_ro_zero:
    assert property (REG_RDATA[15:11] == 5'h00 && !REG_RDATA[5])
    else $error("reserved bits read nonzero");
  a_reset_run:
    assert property ($rose(RESET_N) |-> ##1 (SENSOR_EN && TIMEOUT_EN))
    else $error("sensor idle after reset");
  a_en_tied:
    assert property (TIMEOUT_EN == SENSOR_EN && CONV_EN == SENSOR_EN)
    else $error("enables disagree");
  a_clear_ok: assert property (s_clear_wr |=> SENSOR_EN)
    else $error("shutdown clear refused");
  a_nv_read: assert property (NV_RD_REQ |=> NV_RD_GO)
    else $error("nv read blocked");
  a_nv_write: assert property (!SENSOR_EN [*2] |-> !NV_WR_GO)
    else $error("nv write in shutdown");
  a_above_set:
    assert property (s_conv ##0 $signed(CONV_TEMP) > $signed(UPPER_LIMIT)
      |-> ##2 ABOVE_WINDOW) else $error("above not set");
  a_above_clr:
    assert property (s_conv ##0
      $signed(CONV_TEMP) <= $signed(UPPER_LIMIT) - HMAX
      |-> ##2 !ABOVE_WINDOW) else $error("above not cleared");
  a_below_clr:
    assert property (s_conv ##0 $signed(CONV_TEMP) >= $signed(LOWER_LIMIT)
      |-> ##2 !BELOW_WINDOW) else $error("below not cleared");
  a_below_set:
    assert property (s_conv ##0
      $signed(CONV_TEMP) <= $signed(LOWER_LIMIT) - HMAX
      |-> ##2 BELOW_WINDOW) else $error("below not set");
endmodule // tcfg_top_sva

bind tcfg_top tcfg_top_sva #(.OFF_CYCLES(OFF_CYCLES)) tcfg_top_sva_i (
  .CLK, .RESET_N, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .CONV_DONE,
  .CONV_TEMP, .UPPER_LIMIT, .LOWER_LIMIT, .FACTORY_AUTO_OFF, .NV_RD_REQ,
  .NV_WR_GO, .NV_RD_GO, .TIMEOUT_EN, .SENSOR_EN, .CONV_EN, .ABOVE_WINDOW,
  .BELOW_WINDOW
);

//--- bench/tcfg_host.sv
// Bus host model for the configuration register port
`timescale 1ns/1ps
module tcfg_host
  import tcfg_pkg::*;
(
  input wire logic clk,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata
);
  // ****
  // Transfers
  // ****
  // Idle lines show the inverse, so a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d & ~CFG_RO_MASK;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    // Return once the written state has reached the outputs
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // tcfg_host

//--- bench/thermal_config_hysteresis_shutdown_test.sv
// Self-checking bench of the thermal configuration block
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
module thermal_config_hysteresis_shutdown_test
  import tcfg_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr, reg_rd, nv_wr_go, nv_rd_go, tmo_en, sens_en, conv_en;
  logic above, below, above_crit, alert_out, alert_oe_n, ea, eb, oe;
  logic conv_done = 1'b0;
  logic auto_off = 1'b0;
  logic supply_ok = 1'b0;
  logic nv_wr_req = 1'b0;
  logic nv_rd_req = 1'b0;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [15:0] lk [2] = '{16'h0040, 16'h0080};
  logic signed [12:0] temp = 13'h0000;
  logic signed [12:0] upper = 13'h0100;
  logic signed [12:0] lower = 13'h0000;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 32'h7139;
  int u, h;
  int pt [7];
  tcfg_top #(.OFF_CYCLES(8)) tcfg_top_i (
    .CLK(clk), .RESET_N(reset_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .CONV_DONE(conv_done), .CONV_TEMP(temp), .UPPER_LIMIT(upper),
    .LOWER_LIMIT(lower), .CRIT_LIMIT(13'h0FFF), .FACTORY_AUTO_OFF(auto_off),
    .SUPPLY_OK(supply_ok), .NV_WR_REQ(nv_wr_req), .NV_RD_REQ(nv_rd_req),
    .NV_WR_GO(nv_wr_go), .NV_RD_GO(nv_rd_go), .TIMEOUT_EN(tmo_en),
    .SENSOR_EN(sens_en), .CONV_EN(conv_en), .ABOVE_WINDOW(above),
    .BELOW_WINDOW(below), .ABOVE_CRIT(above_crit), .ALERT_OUT(alert_out),
    .ALERT_OE_N(alert_oe_n)
  );
  tcfg_host tcfg_host_i (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);
  initial
    forever #50 clk = ~clk;
  // ****
  // Expectation and drivers
  // ****
  function automatic int hy(input int c);
    case (c)
      0: return int'(HYST_OFF);
      1: return int'(HYST_1P5);
      2: return int'(HYST_3P0);
      default: return int'(HYST_6P0);
    endcase
  endfunction
  function automatic logic nxt(input logic clr, input logic set, logic old);
    return clr ? 1'b0 : (set ? 1'b1 : old);
  endfunction
  task automatic rst();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    ea = 1'b0;
    eb = 1'b0;
  endtask
  task automatic conv(input int t, input logic on);
    @(posedge clk);
    temp <= 13'(t);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    if (on)
    begin
      ea = nxt(t <= upper - h, t > upper, ea);
      eb = nxt(t >= lower, t <= lower - h, eb);
    end
    `CHK(above, ea, "above flag")
    `CHK(below, eb, "below flag")
    @(negedge clk);
    `CHK(alert_oe_n, ~(oe & on & (ea | eb)), "event pin")
    `CHK({alert_out, above_crit}, 2'b00, "pin data")
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // About twelve times the expected run
  initial
  begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    rst();
    tcfg_host_i.rd(CFG_OFFSET, d);
    `CHK(d, CFG_RESET, "reset value")
    `CHK({sens_en, conv_en, tmo_en}, 3'b111, "running")
    tcfg_host_i.rd(8'h23, d);
    `CHK(d, 16'h0000, "unmapped")
    tcfg_host_i.wr(CFG_OFFSET, 16'h003F);
    tcfg_host_i.rd(CFG_OFFSET, d);
    `CHK(d & 16'hFFEF, 16'h000F, "low bits")
    $display("test register done");
    for (int c = 0; c < 4; c++)
    begin
      u = 200 + ($random(seed) & 255);
      h = hy(c);
      oe = 1'b1;
      @(posedge clk);
      upper <= 13'(u);
      lower <= 13'(u - 200);
      tcfg_host_i.wr(CFG_OFFSET, 16'(c << 9) | 16'h0008);
      tcfg_host_i.rd(CFG_OFFSET, d);
      `CHK(d & 16'hFFEF, 16'(c << 9) | 16'h0008, "hyst code")
      pt = '{u - 100, u + 1, u - h + 1, u - h, u - 201, u - 200 - h, u - 200};
      foreach (pt[k])
        conv(pt[k], 1'b1);
      repeat (6)
        conv(u - 230 + ($random(seed) & 255), 1'b1);
    end
    $display("test hysteresis done");
    oe = 1'b1;
    h = 0;
    tcfg_host_i.wr(CFG_OFFSET, 16'h0108);
    `CHK({sens_en, conv_en, tmo_en}, 3'b000, "shutdown")
    @(posedge clk);
    nv_wr_req <= 1'b1;
    nv_rd_req <= 1'b1;
    conv(u + 1, 1'b0);
    `CHK({nv_rd_go, nv_wr_go}, 2'b10, "nv shutdown")
    tcfg_host_i.wr(CFG_OFFSET, 16'h0008);
    `CHK({sens_en, conv_en, tmo_en}, 3'b111, "restart")
    conv(u + 1, 1'b1);
    `CHK({nv_rd_go, nv_wr_go}, 2'b11, "nv running")
    @(posedge clk);
    nv_wr_req <= 1'b0;
    nv_rd_req <= 1'b0;
    $display("test shutdown done");
    foreach (lk[i])
    begin
      rst();
      tcfg_host_i.wr(CFG_OFFSET, 16'h0300 | lk[i]);
      tcfg_host_i.wr(CFG_OFFSET, 16'h0600 | lk[i]);
      `CHK(sens_en, 1'b1, "locked clear")
      tcfg_host_i.wr(CFG_OFFSET, 16'h0100);
      `CHK(sens_en, 1'b1, "locked set")
      tcfg_host_i.rd(CFG_OFFSET, d);
      `CHK(d & 16'hFFEF, 16'h0200 | lk[i], "locked")
    end
    $display("test lock done");
    @(posedge clk);
    auto_off <= 1'b1;
    supply_ok <= 1'b1;
    rst();
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK(sens_en, 1'b1, "supply good")
    @(posedge clk);
    supply_ok <= 1'b0;
    rst();
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK(sens_en, 1'b0, "auto off")
    tcfg_host_i.rd(CFG_OFFSET, d);
    `CHK(d & 16'hFFEF, 16'h0100, "auto off cfg")
    tcfg_host_i.wr(CFG_OFFSET, 16'h0000);
    `CHK(sens_en, 1'b1, "auto restart")
    $display("test auto off done");
    conclude();
  end
endmodule // thermal_config_hysteresis_shutdown_test
